// *** energy_pulse_output_gen.sv ***
// Digital-to-frequency output stage of an energy meter with a Wishbone register port
//
// Summary of operation
// R01: Calibration rate is slow rate times 128/64/64/32/32/16/16/2048 per select code.
// R02: Slow pulses alternate between the two slow outputs, never together.
// R03: Slow pulse width becomes half the period when the period drops below 240 ms.
// R04: Calibration pulse is active high, 90 ms wide, rate proportional to power.
// R05: Calibration pulse width becomes half the period below a 180 ms period.
// R06: High frequency mode fixes calibration pulse width at 35 microseconds.
// R07: Power below 0.00244 percent of full scale yields no pulses at all.
// R08: Reverse flag goes high on negative power, low on positive power.
// R09: Reverse flag changes only at a calibration pulse moment.
// R10: Full-scale ac input gives slow rate 0.204 times the base frequency.
// R11: Half-scale ac inputs give slow rate 0.051 times the base frequency.
// R12: Calibration output uses the same power value over a shorter accumulation.
// R13: Rate selects pick oscillator divided by 2^19, 2^18, 2^17 or 2^16.
// R14: Slow outputs pulse active low.
// R15: While the reverse flag is high no output pulses are generated.
// R16: Only positive power is integrated toward output pulses.
// R17: Reset holds outputs inactive, clears accumulators, reverse flag low.
// R18: Outside counter averages calibration pulses over its own timer interval.
`timescale 1ns/1ns
`include "energy_pulse_params.svh"
module energy_pulse_output_gen import energy_pulse_pkg::*; #(
    parameter int PW = 24,
    parameter int BASE_LOG2 = `BASE_LOG2_DEF,
    parameter int OSC_DIV = `CLK_KHZ / `OSC_KHZ,
    parameter int CF_WIDTH_CYC = `CF_WIDTH_MS * `CLK_KHZ,
    // Thresholds follow the nominal widths, so shortened widths keep the same ratio
    parameter int CF_HALF_CYC = int'((longint'(CF_WIDTH_CYC) * `CF_HALF_MS) / `CF_WIDTH_MS),
    parameter int SLOW_WIDTH_CYC = `SLOW_WIDTH_MS * `CLK_KHZ,
    parameter int SLOW_HALF_CYC = int'((longint'(SLOW_WIDTH_CYC) * `SLOW_HALF_MS) / `SLOW_WIDTH_MS)
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic STB_I,
    input wire logic CYC_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic IRQ_O,
    input wire logic signed [PW-1:0] POWER_I,
    input wire logic CAL_SCALE_SELECT_I,
    input wire logic RATE_SELECT_HI_I,
    input wire logic RATE_SELECT_LO_I,
    output logic SLOW_PULSE_A_N_O,
    output logic SLOW_PULSE_B_N_O,
    output logic CALIBRATION_PULSE_OUT_O,
    output logic REVERSE_POWER_FLAG_O
);

    // ********************
    // Constants and helpers
    // ********************
    localparam int HF_WIDTH_CYC = `HF_WIDTH_US * `CLK_MHZ;
    localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
    localparam logic [PW-1:0] NOLOAD_TH = PW'(((64'h1 << (PW - 1)) * `NOLOAD_NUM) / `NOLOAD_DEN);

    function automatic logic [ACC_W-1:0] pow2(input logic [5:0] sh);
        pow2 = ACC_W'(1) << sh;
    endfunction

    function automatic logic [5:0] cf_log2(input logic cal_scale_select, input logic hi, input logic lo);
        case ({cal_scale_select, hi, lo})
            3'h4: cf_log2 = `CF_LOG2_128;
            3'h0, 3'h5: cf_log2 = `CF_LOG2_64;
            3'h1, 3'h6: cf_log2 = `CF_LOG2_32;
            3'h2, 3'h7: cf_log2 = `CF_LOG2_16;
            3'h3: cf_log2 = `CF_LOG2_2048;
            default: cf_log2 = `CF_LOG2_16;
        endcase
    endfunction

    top_state_t s_r;
    top_state_t s_nxt;
    logic osc_tick;
    logic [PW-1:0] mag;
    logic [PW-1:0] eff;
    logic [ACC_W-1:0] pos_add;
    logic [ACC_W-1:0] neg_add;
    logic [5:0] slow_sh;
    logic [5:0] cf_sh;
    logic [ACC_W-1:0] slow_lim;
    logic [ACC_W-1:0] cf_lim;
    logic hf_mode;
    logic slow_ovf;
    logic cf_ovf;
    logic neg_ovf;
    logic cf_fire;
    logic slow_fire;
    logic moment;
    logic cf_active;
    logic slow_active;
    logic req;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [31:0] rd;

    // ********************
    // Power conditioning
    // ********************
    always_comb begin
        osc_tick = (s_r.osc_cnt == OSC_LAST);
        mag = POWER_I[PW-1] ? PW'(-POWER_I) : PW'(POWER_I);
        // Creep guard: small loads never reach any of the three accumulators
        eff = (mag >= NOLOAD_TH) ? mag : '0; // R07
        pos_add = POWER_I[PW-1] ? '0 : ACC_W'(eff); // R16
        neg_add = POWER_I[PW-1] ? ACC_W'(eff) : '0; // R08
        hf_mode = !CAL_SCALE_SELECT_I && RATE_SELECT_HI_I && RATE_SELECT_LO_I;
        // Input is a fraction of 2^(PW-1); full scale ac is 0.204, half scale 0.051
        slow_sh = 6'(PW - 1 + BASE_LOG2) - {4'h0, RATE_SELECT_HI_I, RATE_SELECT_LO_I}; // R13 R10 R11
        cf_sh = slow_sh - cf_log2(CAL_SCALE_SELECT_I, RATE_SELECT_HI_I, RATE_SELECT_LO_I); // R01
        slow_lim = pow2(slow_sh);
        cf_lim = pow2(cf_sh);
    end

    // ********************
    // Accumulators
    // ********************
    rate_accum slow_acc (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .step_i(osc_tick),
        .add_i(pos_add),
        .limit_i(slow_lim),
        .ovf_o(slow_ovf)
    );

    // Same input as the slow path, far smaller threshold, so less averaging
    rate_accum cf_acc ( // R12
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .step_i(osc_tick),
        .add_i(pos_add),
        .limit_i(cf_lim),
        .ovf_o(cf_ovf)
    );

    // Negative energy paces the reverse flag so that it can rise while no positive energy reaches cf_acc
    rate_accum neg_acc (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .step_i(osc_tick),
        .add_i(neg_add),
        .limit_i(cf_lim),
        .ovf_o(neg_ovf)
    );

    // ********************
    // Pulse shaping
    // ********************
    always_comb begin
        moment = cf_ovf || neg_ovf; // R09
        cf_fire = cf_ovf && s_r.en; // R15
        slow_fire = slow_ovf && s_r.en && !s_r.rev && !neg_ovf; // R15
    end

    pulse_width_gen cf_pulse (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .fire_i(cf_fire),
        .nom_i(hf_mode ? CNT_W'(HF_WIDTH_CYC) : CNT_W'(CF_WIDTH_CYC)), // R04 R06
        .half_lim_i(CNT_W'(CF_HALF_CYC)), // R05
        .fixed_i(hf_mode), // R06
        .active_o(cf_active)
    );

    pulse_width_gen slow_pulse (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .fire_i(slow_fire),
        .nom_i(CNT_W'(SLOW_WIDTH_CYC)),
        .half_lim_i(CNT_W'(SLOW_HALF_CYC)), // R03
        .fixed_i(1'b0),
        .active_o(slow_active)
    );

    // ********************
    // State update and register port
    // ********************
    always_comb begin
        s_nxt = s_r;
        s_nxt.osc_cnt = osc_tick ? 16'h0000 : s_r.osc_cnt + 16'h0001;
        if (moment) begin
            s_nxt.rev = neg_ovf; // R08 R09
        end
        if (slow_fire) begin
            s_nxt.side = !s_r.side; // R02
        end
        s_nxt.slow_a_n = !(slow_active && s_r.side); // R02 R14
        s_nxt.slow_b_n = !(slow_active && !s_r.side); // R02 R14
        s_nxt.cal = cf_active; // R04
        if (cf_fire) begin
            s_nxt.cf_count = s_r.cf_count + 32'h0000_0001;
        end
        ev = 3'h0;
        ev[`IRQ_CF] = cf_fire;
        ev[`IRQ_SLOW] = slow_fire;
        ev[`IRQ_REV] = moment && (neg_ovf != s_r.rev);
        req = CYC_I && STB_I && !s_r.ack;
        clr = 3'h0;
        rd = 32'h0000_0000;
        case (ADR_I)
            `ADR_STATUS: rd = {27'h0, s_r.cal, !s_r.slow_b_n, !s_r.slow_a_n, hf_mode, s_r.rev};
            `ADR_IRQ_STAT: rd = {29'h0, s_r.ist};
            `ADR_IRQ_EN: rd = {29'h0, s_r.ien};
            `ADR_CTRL: rd = {31'h0, s_r.en};
            `ADR_CF_COUNT: rd = s_r.cf_count;
            default: rd = 32'h0000_0000;
        endcase
        if (req && WE_I && SEL_I[0]) begin
            case (ADR_I)
                `ADR_IRQ_CLR: clr = DAT_I[2:0];
                `ADR_IRQ_EN: s_nxt.ien = DAT_I[2:0];
                `ADR_CTRL: s_nxt.en = DAT_I[`CTRL_EN_BIT];
                default: ;
            endcase
        end
        // A new event outranks a clear in the same cycle
        s_nxt.ist = (s_r.ist & ~clr) | ev;
        s_nxt.irq = |(s_nxt.ist & s_nxt.ien);
        s_nxt.ack = req;
        s_nxt.dat = req ? rd : 32'h0000_0000;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_r <= '0; // R17
            s_r.slow_a_n <= 1'b1; // R17
            s_r.slow_b_n <= 1'b1; // R17
            s_r.en <= `CTRL_RST;
            s_r.ien <= `IRQ_EN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign DAT_O = s_r.dat;
    assign ACK_O = s_r.ack;
    assign IRQ_O = s_r.irq;
    assign SLOW_PULSE_A_N_O = s_r.slow_a_n;
    assign SLOW_PULSE_B_N_O = s_r.slow_b_n;
    assign CALIBRATION_PULSE_OUT_O = s_r.cal;
    assign REVERSE_POWER_FLAG_O = s_r.rev;

    // ********************
    // Assertions
    // ********************
    logic [31:0] cal_len;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cal_len <= 32'h0000_0000;
        end else if (CALIBRATION_PULSE_OUT_O) begin
            cal_len <= cal_len + 32'h0000_0001;
        end else begin
            cal_len <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    a_slow_never_both: assert property (!(!SLOW_PULSE_A_N_O && !SLOW_PULSE_B_N_O)) // R02
        else $error("Both slow outputs active together");
    a_slow_order_alternates: assert property ($fell(SLOW_PULSE_A_N_O) |-> s_r.side) // R02
        else $error("Slow output A pulsed out of turn");
    a_rev_blocks_cal: assert property ($rose(CALIBRATION_PULSE_OUT_O) |-> $past(!s_nxt.rev, 2)) // R15
        else $error("Calibration pulse started while reverse flag set");
    a_rev_only_at_moment: assert property ($changed(REVERSE_POWER_FLAG_O) |-> $past(moment)) // R09
        else $error("Reverse flag moved outside a pulse moment");
    a_neg_sets_rev: assert property (neg_ovf |=> REVERSE_POWER_FLAG_O) // R08
        else $error("Negative power did not raise reverse flag");
    a_pos_clears_rev: assert property (cf_ovf |=> !REVERSE_POWER_FLAG_O) // R08
        else $error("Positive power did not clear reverse flag");
    // Fixed fast-mode width is checked on its own; it may exceed a shortened nominal width
    a_cal_width_max: assert property (CALIBRATION_PULSE_OUT_O && !hf_mode |-> cal_len < 32'(CF_WIDTH_CYC)) // R04
        else $error("Calibration pulse wider than nominal");
    a_cal_hf_width: assert property ($fell(CALIBRATION_PULSE_OUT_O) && hf_mode && $past(hf_mode)
        |-> cal_len == 32'(HF_WIDTH_CYC)) // R06
        else $error("High frequency pulse width wrong");
    a_creep_no_pulse: assert property (osc_tick && mag < NOLOAD_TH |-> pos_add == '0 && neg_add == '0) // R07
        else $error("Sub-threshold power reached accumulator");
    a_reset_idle: assert property (disable iff (1'b0) RST_I |=> SLOW_PULSE_A_N_O && SLOW_PULSE_B_N_O
        && !CALIBRATION_PULSE_OUT_O && !REVERSE_POWER_FLAG_O) // R17
        else $error("Outputs not idle after reset");

    c_cal_pulse: cover property ($rose(CALIBRATION_PULSE_OUT_O));
    c_slow_a: cover property ($fell(SLOW_PULSE_A_N_O));
    c_slow_b: cover property ($fell(SLOW_PULSE_B_N_O));
    c_rev_rise: cover property ($rose(REVERSE_POWER_FLAG_O));

endmodule

// *** energy_pulse_params.svh ***
// Constants of the energy pulse output generator: clock, timing, scaling and register map
`ifndef ENERGY_PULSE_PARAMS_SVH
`define ENERGY_PULSE_PARAMS_SVH

// ********************
// Clock and oscillator
// ********************
`define CLK_KHZ 100000
`define CLK_MHZ 100
`define OSC_KHZ 450
`define BASE_LOG2_DEF 19

// ********************
// Pulse timing
// ********************
`define CF_WIDTH_MS 90
`define CF_HALF_MS 180
`define SLOW_HALF_MS 240
`define SLOW_WIDTH_MS 120
`define HF_WIDTH_US 35

// ********************
// Creep threshold, 0.00244 percent of full scale
// ********************
`define NOLOAD_NUM 244
`define NOLOAD_DEN 10000000

// ********************
// Calibration multiplier, log2 per select code
// ********************
`define CF_LOG2_128 6'h07
`define CF_LOG2_64 6'h06
`define CF_LOG2_32 6'h05
`define CF_LOG2_16 6'h04
`define CF_LOG2_2048 6'h0B

// ********************
// Register map and fields
// ********************
`define ADR_STATUS 8'h00
`define ADR_IRQ_STAT 8'h04
`define ADR_IRQ_CLR 8'h08
`define ADR_IRQ_EN 8'h0C
`define ADR_CTRL 8'h10
`define ADR_CF_COUNT 8'h14
`define CTRL_EN_BIT 0
`define CTRL_RST 1'b1
`define IRQ_EN_RST 3'h0
`define IRQ_CF 0
`define IRQ_SLOW 1
`define IRQ_REV 2

`endif

// *** energy_pulse_pkg.sv ***
// State types of the energy pulse output generator
package energy_pulse_pkg;

    localparam int ACC_W = 48;
    localparam int CNT_W = 32;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic ovf;
    } accum_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] per;
        logic [CNT_W-1:0] left;
        logic active;
    } pulse_state_t;

    typedef struct packed {
        logic [15:0] osc_cnt;
        logic side;
        logic rev;
        logic slow_a_n;
        logic slow_b_n;
        logic cal;
        logic en;
        logic [2:0] ien;
        logic [2:0] ist;
        logic irq;
        logic [31:0] cf_count;
        logic [31:0] dat;
        logic ack;
    } top_state_t;

endpackage

// *** rate_accum.sv ***
// Energy accumulator that emits one overflow pulse per threshold crossing
`timescale 1ns/1ns
module rate_accum import energy_pulse_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic [ACC_W-1:0] add_i,
    input wire logic [ACC_W-1:0] limit_i,
    output logic ovf_o
);

    accum_state_t s_r;
    accum_state_t s_nxt;
    logic [ACC_W:0] sum;

    assign ovf_o = s_r.ovf;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ovf = 1'b0;
        sum = {1'b0, s_r.acc} + {1'b0, add_i};
        if (step_i) begin
            // Remainder kept, so no energy is lost across pulses
            if (sum >= {1'b0, limit_i}) begin
                s_nxt.acc = ACC_W'(sum - {1'b0, limit_i});
                s_nxt.ovf = 1'b1;
            end else begin
                s_nxt.acc = sum[ACC_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0; // R17
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// *** pulse_width_gen.sv ***
// Pulse shaper: nominal width, or half the measured period when pulses come fast
`timescale 1ns/1ns
module pulse_width_gen import energy_pulse_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [CNT_W-1:0] nom_i,
    input wire logic [CNT_W-1:0] half_lim_i,
    input wire logic fixed_i,
    output logic active_o
);

    pulse_state_t s_r;
    pulse_state_t s_nxt;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] width;

    assign active_o = s_r.active;

    always_comb begin
        s_nxt = s_r;
        // Count restarts at zero after a fire, so one is added back to get the true period
        half = CNT_W'(({1'b0, s_r.per} + {{CNT_W{1'b0}}, 1'b1}) >> 1);
        if (fixed_i) begin
            width = nom_i;
        end else if (s_r.per < half_lim_i) begin
            width = (half == '0) ? CNT_W'(1) : half;
        end else begin
            width = nom_i;
        end
        // Period counter saturates, so the first pulse after a pause takes the nominal width
        if (s_r.per != '1) begin
            s_nxt.per = s_r.per + CNT_W'(1);
        end
        if (s_r.left != '0) begin
            s_nxt.left = s_r.left - CNT_W'(1);
        end
        if (fire_i) begin
            s_nxt.per = '0;
            s_nxt.left = width;
        end
        s_nxt.active = (s_nxt.left != '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.per <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// *** pulse_counter_model.sv ***
// Pulse counter standing where the impulse counter or meter controller sits
`timescale 1ns/1ns
module pulse_counter_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_a_n_i,
    input wire logic slow_b_n_i,
    input wire logic cal_i,
    output int cf_cnt_o,
    output int slow_cnt_o,
    output int cf_w_o,
    output int slow_w_o,
    output int alt_err_o
);
    logic cal_q, lo_q, a_q, b_q, last_b;
    int cw, sw;
    // Edges only: the pulses are asynchronous to the counter's own timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {cal_q, lo_q} <= 2'b00;
            {a_q, b_q, last_b} <= 3'b111;
            {cf_cnt_o, slow_cnt_o, cf_w_o, slow_w_o, alt_err_o, cw, sw} <= '0;
        end else begin
            cal_q <= cal_i;
            a_q <= slow_a_n_i;
            b_q <= slow_b_n_i;
            lo_q <= !slow_a_n_i || !slow_b_n_i;
            cw <= cal_i ? ((cal_q) ? cw + 1 : 1) : cw;
            sw <= (!slow_a_n_i || !slow_b_n_i) ? ((lo_q) ? sw + 1 : 1) : sw;
            if (cal_i && !cal_q) begin
                cf_cnt_o <= cf_cnt_o + 1;
            end
            if (!cal_i && cal_q) begin
                cf_w_o <= cw;
            end
            if (lo_q && slow_a_n_i && slow_b_n_i) begin
                slow_w_o <= sw;
            end
            // Active low, A first, then strictly alternating
            if (a_q && !slow_a_n_i) begin
                slow_cnt_o <= slow_cnt_o + 1;
                last_b <= 1'b0;
                alt_err_o <= alt_err_o + (last_b ? 0 : 1) + (slow_b_n_i ? 0 : 1);
            end
            if (b_q && !slow_b_n_i) begin
                slow_cnt_o <= slow_cnt_o + 1;
                last_b <= 1'b1;
                alt_err_o <= alt_err_o + (last_b ? 1 : 0);
            end
        end
    end
endmodule

// *** energy_pulse_output_gen_test.sv ***
// Self-checking testbench of the energy pulse output generator
`timescale 1ns/1ns
`include "energy_pulse_params.svh"
module energy_pulse_output_gen_test;
    localparam int HF_W = `HF_WIDTH_US * `CLK_MHZ;
    logic clk, rst, we, stb, cyc, cal_scale_select, hi, lo, ack_o, irq_o, a_n, b_n, cal, rev;
    logic [7:0] adr;
    logic [31:0] wdat, rd, c1, dat_o;
    logic [3:0] sel;
    logic signed [17:0] pwr;
    int error_cnt, compares, cyc_cnt, cf_cnt, slow_cnt, cf_w, slow_w, alt_err, k, n0, n1;
    logic [2:0] codes [7] = '{3'b100, 3'b000, 3'b101, 3'b001, 3'b110, 3'b010, 3'b111};
    int mults [7] = '{128, 64, 64, 32, 32, 16, 16};

    // Shortened counts keep the run to about eleven thousand cycles
    // PW-1+BASE_LOG2 stays 15 for short thresholds, while an 18-bit input gives a creep floor of 3
    energy_pulse_output_gen #(.PW(18), .BASE_LOG2(-2), .OSC_DIV(2), .CF_WIDTH_CYC(40),
        .SLOW_WIDTH_CYC(60)) dut_u (.CLK_I(clk), .RST_I(rst), .ADR_I(adr),
        .DAT_I(wdat), .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_o), .ACK_O(ack_o),
        .IRQ_O(irq_o), .POWER_I(pwr), .CAL_SCALE_SELECT_I(cal_scale_select), .RATE_SELECT_HI_I(hi),
        .RATE_SELECT_LO_I(lo), .SLOW_PULSE_A_N_O(a_n), .SLOW_PULSE_B_N_O(b_n),
        .CALIBRATION_PULSE_OUT_O(cal), .REVERSE_POWER_FLAG_O(rev));
    pulse_counter_model partner_u (.clk_i(clk), .rst_i(rst), .slow_a_n_i(a_n), .slow_b_n_i(b_n),
        .cal_i(cal), .cf_cnt_o(cf_cnt), .slow_cnt_o(slow_cnt), .cf_w_o(cf_w), .slow_w_o(slow_w),
        .alt_err_o(alt_err));

    // ********************
    // Tasks
    // ********************
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    // Classic cycle; held until ack is sampled, released at that same edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        chk({31'h0, ack_o}, 32'h1, "bus ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    function automatic int mon(input int s);
        return (s == 0) ? cf_cnt : (s == 1) ? slow_cnt : cf_w;
    endfunction

    task automatic wait_mon(input int s, input int t);
        int w;
        w = 0;
        while (mon(s) < t && w < 20000) begin
            @(posedge clk);
            w++;
        end
        chk(mon(s) >= t, 32'h1, "pulse wait");
    endtask

    task automatic do_reset(input logic [2:0] code, input logic signed [17:0] p);
        @(posedge clk);
        rst <= 1'b1;
        {cal_scale_select, hi, lo} <= code;
        pwr <= p;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard well beyond the expected run length
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 90000) begin
            error_cnt++;
            conclude();
        end
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        {rst, we, stb, cyc, cal_scale_select, hi, lo} = 7'b1000100;
        {adr, wdat, sel, pwr} = '0;
        sel = 4'hF;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({a_n, b_n, cal, rev, irq_o}, 5'b11000, "outputs after reset");
        wb(`ADR_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h1, "ctrl reset");
        wb(`ADR_IRQ_EN, 1'b0, 32'h0);
        chk(rd, 32'h0, "irq enable reset");
        wb(`ADR_CF_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h0, "count reset");
        wb(8'h20, 1'b0, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            do_reset(codes[i], codes[i][2] ? 18'sd64 : 18'sd128);
            wait_mon(1, 1);
            wb(`ADR_CF_COUNT, 1'b0, 32'h0);
            c1 = rd;
            wait_mon(1, 2);
            wb(`ADR_CF_COUNT, 1'b0, 32'h0);
            chk(rd - c1, mults[i], "cal pulses per slow pulse");
        end
        chk(slow_w, 60, "slow nominal width");
        chk(cf_w, 4, "cal half period width");
        pwr <= 18'sd128;
        wait_mon(1, slow_cnt + 3);
        chk(slow_w, 32, "slow half period width");
        chk(alt_err, 0, "slow alternation");
        $display("test ratios done");
        do_reset(3'b100, 18'sd4);
        wait_mon(0, 2);
        chk(cf_w, 40, "cal nominal width");
        // Without the floor this power would give a pulse every 256 cycles
        pwr <= 18'sd2;
        n0 = cf_cnt;
        repeat (600) @(posedge clk);
        chk(cf_cnt, n0, "no pulse below creep floor");
        wb(`ADR_CTRL, 1'b1, 32'h0);
        pwr <= 18'sd64;
        repeat (300) @(posedge clk);
        chk(cf_cnt, n0, "outputs disabled");
        wb(`ADR_CTRL, 1'b1, 32'h1);
        wait_mon(0, n0 + 2);
        $display("test widths done");
        // One oscillator tick at this power gives exactly one fire
        do_reset(3'b011, 18'sd3);
        repeat (3) @(posedge clk);
        pwr <= 18'sd0;
        wait_mon(2, 1);
        chk(cf_w, HF_W, "fixed width in fast mode");
        wb(`ADR_STATUS, 1'b0, 32'h0);
        chk(rd[1], 1'b1, "fast mode status");
        $display("test fast mode done");
        do_reset(3'b100, -18'sd64);
        wb(`ADR_IRQ_EN, 1'b1, 32'h5);
        for (k = 0; k < 3000 && rev !== 1'b1; k++) @(posedge clk);
        chk(rev, 1'b1, "reverse on negative power");
        n0 = cf_cnt;
        n1 = slow_cnt;
        repeat (400) @(posedge clk);
        chk(cf_cnt, n0, "no cal pulse in reverse");
        chk(slow_cnt, n1, "no slow pulse in reverse");
        chk(irq_o, 1'b1, "reverse interrupt");
        wb(`ADR_IRQ_STAT, 1'b0, 32'h0);
        chk(rd[2], 1'b1, "reverse event sticky");
        wb(`ADR_IRQ_CLR, 1'b1, 32'h7);
        repeat (2) @(posedge clk);
        chk(irq_o, 1'b0, "interrupt cleared");
        wb(`ADR_IRQ_STAT, 1'b0, 32'h0);
        chk(rd, 32'h0, "status cleared");
        pwr <= 18'sd64;
        for (k = 0; k < 3000 && rev !== 1'b0; k++) @(posedge clk);
        chk(rev, 1'b0, "reverse off on positive power");
        @(posedge clk);
        chk(cal, 1'b1, "flag moves with a cal pulse");
        wait_mon(0, n0 + 2);
        repeat (2) @(posedge clk);
        chk(irq_o, 1'b1, "cal interrupt");
        wb(`ADR_IRQ_EN, 1'b1, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq_o, 1'b0, "interrupt masked");
        $display("test reverse done");
        conclude();
    end
endmodule
